/* include/frt_params.svh */
/*
 * Offsets, field positions, reset values and timing figures of the timer block.
 * Assumes a single 20 MHz system clock and byte-wide register accesses.
 */
// Functional notes
// - Timer runs from own timebase, accesses synchronous
// - 16-bit free counter counts at 4/6 MHz, wraps
// - Free count is the capture time base
// - Low byte read holds upper byte copy
// - Sample on low read, load on high write
// - Periodic event every 1024 microseconds
// - Event on every free counter wrap
// - Wrap event uses priority 17, vector 44h
// - Interval value read latches upper nibble
// - Upper nibble read: held bits, top zero
`ifndef FRT_PARAMS_SVH
`define FRT_PARAMS_SVH

// Register offsets.
`define FRT_OFS_FREE_LO     8'h20
`define FRT_OFS_FREE_HI     8'h21
`define FRT_OFS_INTV_LO     8'h26
`define FRT_OFS_INTV_HI     8'h27
`define FRT_OFS_RELOAD_LO   8'h28
`define FRT_OFS_RELOAD_HI   8'h29
`define FRT_OFS_CONFIG      8'h2a
`define FRT_OFS_STATUS      8'h2b
`define FRT_OFS_MASK        8'h2c
`define FRT_OFS_CAPT_LO     8'h2d
`define FRT_OFS_CAPT_HI     8'h2e

// Reset values.
`define FRT_RST_BYTE        8'h00
`define FRT_RST_FREE        16'h0000
`define FRT_RST_INTV        12'h000
`define FRT_RST_EVENTS      3'h0
`define FRT_RST_ACC         6'h00
`define FRT_RST_US          3'h0
`define FRT_RST_NIBBLE      4'h0

// Field positions.
`define FRT_CFG_SEL6_BIT    0

// Timing: system clock and timebase rates in MHz, periodic interval in microseconds.
`define FRT_CLK_MHZ         6'h14
`define FRT_TB_SLOW_MHZ     6'h04
`define FRT_TB_FAST_MHZ     6'h06
`define FRT_PERIOD_US       1024
`define FRT_PERIOD_CNT_W    $clog2(`FRT_PERIOD_US)

// Interrupt priorities and vectors.
`define FRT_PRIO_MS         5'h0d
`define FRT_PRIO_INTV       5'h0e
`define FRT_PRIO_WRAP       5'h11
`define FRT_VEC_MS          8'h34
`define FRT_VEC_INTV        8'h38
`define FRT_VEC_WRAP        8'h44
`define FRT_VEC_NONE        8'h00

`endif

/* include/frt_pkg.sv */
/*
 * Types shared by the timer block.
 * Assumes frt_params.svh supplies all numeric constants.
 */
package frt_pkg;

    // Bit positions of the three events in status and mask.
    typedef enum logic [1:0]
    {
        FRT_EV_MS   = 2'h0,
        FRT_EV_INTV = 2'h1,
        FRT_EV_WRAP = 2'h2
    } frt_event_t;

    typedef logic [7:0] frt_addr_t;
    typedef logic [7:0] frt_byte_t;

endpackage : frt_pkg

/* rtl/frt_timer.sv */
/*
 * Free-running 16-bit counter and 12-bit programmable interval timer with
 * a byte-wide register port, sticky event status and one interrupt line.
 * Assumes a 20 MHz clock, a synchronous active-high reset and a register
 * master that never asserts both strobes at once.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "frt_params.svh"

module frt_timer
#(
    parameter int INTV_W = 12,
    parameter int FREE_W = 16
)
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              srst,
    // Register port.
    input  wire frt_pkg::frt_addr_t addr,
    input  wire frt_pkg::frt_byte_t wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output frt_pkg::frt_byte_t     rd_data,
    // Capture pin, asynchronous to clk.
    input  wire logic              capture_in,
    // Interrupt outputs.
    output logic                   irq,
    output logic [7:0]             irq_vector
);

    // Width of the microsecond count that spans one periodic interval.
    localparam int MS_W = `FRT_PERIOD_CNT_W;

    // Timebase state.
    logic [5:0]          tb_acc;
    logic [6:0]          next_tb_sum;
    logic [5:0]          tb_rate;
    logic                tb_tick;
    logic [2:0]          us_cnt;
    logic                us_tick;
    logic [MS_W-1:0]     ms_cnt;

    // Counters and holding registers.
    logic [FREE_W-1:0]   free_cnt;
    logic [7:0]          free_lo_pend;
    logic [7:0]          free_hold;
    logic [INTV_W-1:0]   intv_cnt;
    logic [INTV_W-1:0]   reload;
    logic [3:0]          intv_hold;
    logic [FREE_W-1:0]   capt;

    // Control and interrupt registers.
    logic [7:0]          config_reg;
    logic [2:0]          status;
    logic [2:0]          mask;
    logic [2:0]          ev;
    logic [2:0]          pending;

    // Capture synchroniser.
    logic                cap_s1;
    logic                cap_s2;
    logic                cap_s3;
    logic                cap_lvl;
    logic                cap_edge;

    // Decoded accesses.
    logic                wr_free_lo;
    logic                wr_free_hi;
    logic                wr_rel_lo;
    logic                wr_rel_hi;
    logic                wr_cfg;
    logic                wr_mask;
    logic                rd_free_lo;
    logic                rd_intv_lo;
    logic                rd_status;

    // Decodes are plain compares; unmapped offsets fall through to zero.
    assign wr_free_lo = wr_en && (addr == `FRT_OFS_FREE_LO);
    assign wr_free_hi = wr_en && (addr == `FRT_OFS_FREE_HI);
    assign wr_rel_lo  = wr_en && (addr == `FRT_OFS_RELOAD_LO);
    assign wr_rel_hi  = wr_en && (addr == `FRT_OFS_RELOAD_HI);
    assign wr_cfg     = wr_en && (addr == `FRT_OFS_CONFIG);
    assign wr_mask    = wr_en && (addr == `FRT_OFS_MASK);
    assign rd_free_lo = rd_en && (addr == `FRT_OFS_FREE_LO);
    assign rd_intv_lo = rd_en && (addr == `FRT_OFS_INTV_LO);
    assign rd_status  = rd_en && (addr == `FRT_OFS_STATUS);

    // The timebase is a fractional divider off clk, so both 4 and 6 MHz keep
    // an exact average rate even though 20 MHz is not a multiple of 6.
    // Own timebase tick
    assign tb_rate = config_reg[`FRT_CFG_SEL6_BIT] ? `FRT_TB_FAST_MHZ : `FRT_TB_SLOW_MHZ;

    always_comb
    begin
        next_tb_sum = {1'b0, tb_acc} + {1'b0, tb_rate};
        tb_tick     = (next_tb_sum >= {1'b0, `FRT_CLK_MHZ});
    end

    // Accumulator of the fractional divider.
    always_ff @(posedge clk)
    begin
        if (srst)
            tb_acc <= `FRT_RST_ACC;
        else if (tb_tick)
            tb_acc <= 6'(next_tb_sum - {1'b0, `FRT_CLK_MHZ});
        else
            tb_acc <= next_tb_sum[5:0];
    end

    // One microsecond is tb_rate timebase ticks. The compare is >= so that a
    // rate change in mid-count cannot strand the counter above its end.
    assign us_tick = tb_tick && ({3'h0, us_cnt} >= (tb_rate - 6'h01));

    always_ff @(posedge clk)
    begin
        if (srst)
            us_cnt <= `FRT_RST_US;
        else if (us_tick)
            us_cnt <= 3'h0;
        else if (tb_tick)
            us_cnt <= us_cnt + 3'h1;
    end

    // Microsecond count that rolls over once per periodic interval.
    // It ignores writes to the free count, so the periodic rate never jitters.
    always_ff @(posedge clk)
    begin
        if (srst)
            ms_cnt <= '0;
        else if (us_tick)
            ms_cnt <= ms_cnt + MS_W'(1);
    end

    // A write to the low byte is parked until the high byte arrives.
    // Low byte first
    always_ff @(posedge clk)
    begin
        if (srst)
            free_lo_pend <= `FRT_RST_BYTE;
        else if (wr_free_lo)
            free_lo_pend <= wr_data;
    end

    // Free counter: the high-byte write loads all 16 bits in one cycle, which
    // takes precedence over the tick in that cycle.
    // Load on high write
    always_ff @(posedge clk)
    begin
        if (srst)
            free_cnt <= `FRT_RST_FREE;
        else if (wr_free_hi)
            free_cnt <= {wr_data, free_lo_pend};
        else if (tb_tick)
            free_cnt <= free_cnt + FREE_W'(1);
    end

    // The high byte is copied in the cycle the low byte is read.
    // A high read with no low read before it returns the older copy.
    // Hold upper byte
    always_ff @(posedge clk)
    begin
        if (srst)
            free_hold <= `FRT_RST_BYTE;
        else if (rd_free_lo)
            free_hold <= free_cnt[15:8];
    end

    // Capture pin passes three flops; the level changes only when the second
    // and third agree, which rejects single-sample glitches.
    // Only the second stage reads the first, so a metastable sample settles.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cap_s1  <= 1'b0;
            cap_s2  <= 1'b0;
            cap_s3  <= 1'b0;
            cap_lvl <= 1'b0;
        end
        else
        begin
            cap_s1 <= capture_in;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
            if (cap_s2 == cap_s3)
                cap_lvl <= cap_s3;
        end
    end

    assign cap_edge = (cap_s2 == cap_s3) && cap_s3 && !cap_lvl;

    // A rising capture edge samples the free count.
    // Capture time base
    always_ff @(posedge clk)
    begin
        if (srst)
            capt <= `FRT_RST_FREE;
        else if (cap_edge)
            capt <= free_cnt;
    end

    // Reload register; the nibble write keeps only bits 3:0.
    // A nibble written before its low byte pairs with a stale low byte.
    // Reload byte order
    always_ff @(posedge clk)
    begin
        if (srst)
            reload <= `FRT_RST_INTV;
        else if (wr_rel_lo)
            reload[7:0] <= wr_data;
        else if (wr_rel_hi)
            reload[11:8] <= wr_data[3:0];
    end

    // Interval counter ticks once per microsecond and reloads at zero.
    // A reload of zero raises the event on every microsecond.
    // Count down, reload
    always_ff @(posedge clk)
    begin
        if (srst)
            intv_cnt <= `FRT_RST_INTV;
        else if (us_tick)
        begin
            if (intv_cnt == '0)
                intv_cnt <= reload;
            else
                intv_cnt <= intv_cnt - INTV_W'(1);
        end
    end

    // Upper nibble held at the instant the low byte is read.
    // Latch upper nibble
    always_ff @(posedge clk)
    begin
        if (srst)
            intv_hold <= `FRT_RST_NIBBLE;
        else if (rd_intv_lo)
            intv_hold <= intv_cnt[11:8];
    end

    // Events of this cycle.
    always_comb
    begin
        ev = `FRT_RST_EVENTS;
        ev[frt_pkg::FRT_EV_MS]   = us_tick && (&ms_cnt);
        ev[frt_pkg::FRT_EV_INTV] = us_tick && (intv_cnt == '0);
        // A load through the high byte is not an overflow, even at all ones.
        // Wrap event
        ev[frt_pkg::FRT_EV_WRAP] = tb_tick && !wr_free_hi && (&free_cnt);
    end

    // Sticky status, cleared by a read; a new event in the read cycle survives.
    // Such an event shows up in the next read, not in this one.
    always_ff @(posedge clk)
    begin
        if (srst)
            status <= `FRT_RST_EVENTS;
        else if (rd_status)
            status <= ev;
        else
            status <= status | ev;
    end

    // Configuration and mask registers.
    // Only the rate select bit is stored; the other bits read back as zero.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            config_reg <= `FRT_RST_BYTE;
            mask       <= `FRT_RST_EVENTS;
        end
        else
        begin
            if (wr_cfg)
                config_reg <= {7'h00, wr_data[`FRT_CFG_SEL6_BIT]};
            if (wr_mask)
                mask <= wr_data[2:0];
        end
    end

    assign pending = status & mask;

    // Interrupt line and vector of the highest-priority pending event.
    // Keeping the vector in a flop holds the output free of decode glitches.
    // The vector follows status by one cycle, like the line itself.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq        <= 1'b0;
            irq_vector <= `FRT_VEC_NONE;
        end
        else
        begin
            irq <= |pending;
            if (pending[frt_pkg::FRT_EV_MS])
                irq_vector <= `FRT_VEC_MS;
            else if (pending[frt_pkg::FRT_EV_INTV])
                irq_vector <= `FRT_VEC_INTV;
            else if (pending[frt_pkg::FRT_EV_WRAP])
                irq_vector <= `FRT_VEC_WRAP;
            else
                irq_vector <= `FRT_VEC_NONE;
        end
    end

    // Read data stand in the cycle after the strobe only; zero otherwise and
    // for unmapped offsets.
    // Reads change nothing but the two latches and the status bits.
    always_ff @(posedge clk)
    begin
        if (srst)
            rd_data <= `FRT_RST_BYTE;
        else if (!rd_en)
            rd_data <= `FRT_RST_BYTE;
        else
        begin
            unique case (addr)
                `FRT_OFS_FREE_LO:   rd_data <= free_cnt[7:0];
                `FRT_OFS_FREE_HI:   rd_data <= free_hold;
                `FRT_OFS_INTV_LO:   rd_data <= intv_cnt[7:0];
                `FRT_OFS_INTV_HI:   rd_data <= {4'h0, intv_hold};
                `FRT_OFS_RELOAD_LO: rd_data <= reload[7:0];
                `FRT_OFS_RELOAD_HI: rd_data <= {4'h0, reload[11:8]};
                `FRT_OFS_CONFIG:    rd_data <= config_reg;
                `FRT_OFS_STATUS:    rd_data <= {5'h00, status};
                `FRT_OFS_MASK:      rd_data <= {5'h00, mask};
                `FRT_OFS_CAPT_LO:   rd_data <= capt[7:0];
                `FRT_OFS_CAPT_HI:   rd_data <= capt[15:8];
                default:            rd_data <= `FRT_RST_BYTE;
            endcase
        end
    end

endmodule : frt_timer

/* verification/frt_timer_properties.sv */
/* Port checks of the timer block.
   Assumes a bind to every frt_timer instance and byte-wide accesses. */
`timescale 1ns/100ps
module frt_timer_properties
#(
    parameter int INTV_W = 12,
    parameter int FREE_W = 16
)
(
    // Clock and reset.
    input wire logic               clk,
    input wire logic               srst,
    // Register port.
    input wire frt_pkg::frt_addr_t addr,
    input wire frt_pkg::frt_byte_t wr_data,
    input wire logic               wr_en,
    input wire logic               rd_en,
    input wire frt_pkg::frt_byte_t rd_data,
    // Interrupt outputs.
    input wire logic               irq,
    input wire logic [7:0]         irq_vector
);
    // One clock domain; reset silences every check.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Read answers, held copies and loads, tied to the strobes that cause them, and the legal interrupt vectors.
    idle_read_a:
        assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data outside the read cycle");
    lo_step_a:
        assert property (rd_en && addr == 8'h20 ##1 rd_en && addr == 8'h20
            |=> 8'(rd_data - $past(rd_data)) <= 8'h01)
        else $error("low count byte stepped too far");
    hold_keep_a:
        assert property (rd_en && addr == 8'h21 ##1 rd_en && addr == 8'h21
            |=> rd_data == $past(rd_data))
        else $error("held high byte changed without a low read");
    load_high_a:
        assert property (wr_en && addr == 8'h20 ##1 wr_en && addr == 8'h21
            ##1 rd_en && addr == 8'h20 |=> 8'(rd_data - $past(wr_data, 3)) <= 8'h01)
        else $error("loaded count not seen after high write");
    nib_keep_a:
        assert property (rd_en && addr == 8'h27 ##1 rd_en && addr == 8'h27
            |=> rd_data == $past(rd_data))
        else $error("latched nibble changed without a low read");
    nib_zero_a:
        assert property ($past(rd_en) && $past(addr) inside {8'h27, 8'h29}
            |-> rd_data[7:4] == 4'h0)
        else $error("reserved nibble bits read nonzero");
    reload_back_a:
        assert property (wr_en && addr == 8'h28 ##1 rd_en && addr == 8'h28
            |=> rd_data == $past(wr_data, 2))
        else $error("reload low byte not stored");
    vec_legal_a:
        assert property (irq |-> irq_vector inside {8'h34, 8'h38, 8'h44})
        else $error("interrupt vector not a timer vector");
endmodule : frt_timer_properties

bind frt_timer frt_timer_properties #(.INTV_W(INTV_W), .FREE_W(FREE_W)) prop_inst
(
    .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .irq_vector(irq_vector)
);

/* verification/tb.sv */
/* Self-checking bench of the timer block: registers, counters and interrupts.
   Assumes frt_pkg and the checker are compiled first; capture rises once. */
`timescale 1ns/100ps
module tb;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               wr_en = 1'b0;
    logic               rd_en = 1'b0;
    logic               capture_in = 1'b0;
    logic               irq;
    logic [7:0]         irq_vector;
    logic [15:0]        v1;
    logic [15:0]        v2;
    frt_pkg::frt_addr_t addr = 8'h00;
    frt_pkg::frt_byte_t wr_data = 8'h00;
    frt_pkg::frt_byte_t rd_data;
    frt_pkg::frt_byte_t got;
    int                 fail_count = 0;
    int                 n_checks = 0;
    int                 k;
    frt_pkg::frt_addr_t ra[5] = '{8'h21, 8'h27, 8'h28, 8'h29, 8'h40};

    // A 50 ns clock period.
    always #25 clk = ~clk;

    frt_timer frt_timer_inst
    (
        .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .capture_in(capture_in), .irq(irq),
        .irq_vector(irq_vector)
    );

    // One bus cycle; got then holds the answer to the previous cycle's read.
    task op(input logic w, input logic r, input frt_pkg::frt_addr_t a,
            input frt_pkg::frt_byte_t d);
        @(posedge clk);
        wr_en <= w;
        rd_en <= r;
        addr <= a;
        wr_data <= d;
        #1 got = rd_data;
    endtask : op
    task wr(input frt_pkg::frt_addr_t a, input frt_pkg::frt_byte_t d);
        op(1'b1, 1'b0, a, d);
    endtask : wr
    task rd(input frt_pkg::frt_addr_t a);
        op(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task nop;
        op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask : nop
    // Low byte first
    // The partner byte then comes from the same instant.
    task rd16(input frt_pkg::frt_addr_t a, output logic [15:0] v);
        rd(a);
        rd(a + 8'h01);
        v[7:0] = got;
        nop;
        v[15:8] = got;
    endtask : rd16
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Timebase ticks expected over a span of clock cycles at a given rate.
    function automatic int exp_ticks(input int cycles, input int mhz);
        return cycles * mhz / 20;
    endfunction : exp_ticks
    task test_done;
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Bounded wait, so a dead interrupt line ends the run instead of hanging it.
    task wait_irq(input int lim);
        k = 0;
        while (irq !== 1'b1)
        begin
            @(posedge clk);
            #1 k++;
            if (k > lim)
            begin
                fail_count++;
                test_done;
            end
        end
    endtask : wait_irq

    // Main sequence.
    initial
    begin
        void'($urandom(32'h886b125a));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        wr(8'h40, 8'hff);
        foreach (ra[i])
        begin
            rd(ra[i]);
            rd(ra[i]);
            nop;
            chk("reset value", 16'h0000, {8'h00, got});
        end
        repeat (4)
        begin
            v1 = 16'($urandom);
            wr(8'h28, v1[7:0]);
            rd(8'h28);
            wr(8'h29, v1[15:8]);
            chk("reload low", {8'h00, v1[7:0]}, {8'h00, got});
            rd(8'h29);
            nop;
            chk("reload high", {12'h000, v1[11:8]}, {8'h00, got});
        end
        // The interval count may hold a random reload by now; a mid-run reset
        // clears it, so 16 is in place before the first microsecond tick.
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(8'h29);
        nop;
        chk("reset reload", 16'h0000, {8'h00, got});
        // Reload of 16 gives a 17-step cycle; 103 cycles span about 5 steps.
        wr(8'h28, 8'h10);
        wr(8'h29, 8'h00);
        wr(8'h2c, 8'h00);
        nop;
        repeat (400) @(posedge clk);
        rd16(8'h26, v1);
        repeat (100) @(posedge clk);
        rd16(8'h26, v2);
        k = (int'(v1) + 17 - int'(v2)) % 17;
        chk("interval step", 16'h0001, 16'(v1 <= 16'h0010 && k >= 4 && k <= 6));
        chk("masked irq", 16'h0000, {15'h0000, irq});
        rd(8'h2b);
        nop;
        chk("status", 16'h0002, {8'h00, got});
        wr(8'h2c, 8'h02);
        nop;
        wait_irq(400);
        chk("interval vector", 16'h0038, {8'h00, irq_vector});
        rd(8'h2b);
        nop;
        nop;
        chk("cleared irq", 16'h0000, {15'h0000, irq});
        // A long reload silences the interval timer; a load near the top wraps.
        wr(8'h28, 8'hff);
        wr(8'h29, 8'h0f);
        wr(8'h2c, 8'h04);
        nop;
        repeat (400) @(posedge clk);
        rd(8'h2b);
        v1 = {12'hfff, 4'($urandom)};
        wr(8'h20, v1[7:0]);
        wr(8'h21, 8'hff);
        rd16(8'h20, v2);
        chk("loaded count", 16'h0001, 16'(v2 - v1 <= 16'h0002));
        wait_irq(200);
        chk("wrap vector", 16'h0044, {8'h00, irq_vector});
        // Periodic event: 1024 us is 20480 cycles, less the clearing cycles.
        wr(8'h2c, 8'h01);
        rd(8'h2b);
        nop;
        wait_irq(21000);
        rd(8'h2b);
        nop;
        nop;
        wait_irq(21000);
        chk("period", 16'h0001, 16'(k >= 20470 && k <= 20480));
        chk("periodic vector", 16'h0034, {8'h00, irq_vector});
        // 1003 cycles give about 200 ticks at 4 MHz and 300 at 6 MHz.
        for (int m = 0; m < 2; m++)
        begin
            wr(8'h2a, 8'(m));
            rd(8'h20);
            rd16(8'h20, v1);
            repeat (1000) @(posedge clk);
            rd16(8'h20, v2);
            k = int'(v2 - v1) - exp_ticks(1003, 4 + 2 * m);
            chk("count rate", 16'h0001, 16'(k >= -1 && k <= 2));
        end
        // Capture on rising pin
        // The pin rises at an edge; the filter passes it four cycles later.
        @(posedge clk);
        capture_in <= 1'b1;
        rd16(8'h20, v1);
        rd16(8'h2d, v2);
        chk("capture", 16'h0001, 16'(v2 - v1 <= 16'h0002));
        // A pin that stays high must not capture again.
        repeat (20) @(posedge clk);
        rd16(8'h2d, v1);
        chk("capture held", v2, v1);
        test_done;
    end
endmodule : tb
